// ### bst_pkg.sv
// Shared constants and types for the boundary-scan test access port.
package bst_pkg;

  // Instruction register width and instruction codes.
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h1;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_BYPASS = 4'hF;

  // Fixed pattern loaded into the instruction shift stage on capture.
  localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;

  // Identification register width and default; the value is arbitrary, bit 0 must be one.
  localparam int ID_W = 32;
  localparam logic [31:0] IDCODE_DEFAULT = 32'h0000_0A5B;

  // Reset values of the pin synchronisers; tck idles low, undriven tms, tdi and trst_n read high.
  localparam logic TCK_IDLE = 1'b0;
  localparam logic PULLED_HIGH = 1'b1;

  // Default length of the boundary register.
  localparam int BSR_LEN_DEFAULT = 8;

  // Test controller states.
  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_SEL_DR,
    ST_CAP_DR,
    ST_SHIFT_DR,
    ST_EXIT1_DR,
    ST_PAUSE_DR,
    ST_EXIT2_DR,
    ST_UPD_DR,
    ST_SEL_IR,
    ST_CAP_IR,
    ST_SHIFT_IR,
    ST_EXIT1_IR,
    ST_PAUSE_IR,
    ST_EXIT2_IR,
    ST_UPD_IR
  } bst_tap_state_t;

endpackage : bst_pkg

// ### bst_sync.sv
// Two-stage synchroniser for one test pin entering the system clock domain.
module bst_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);

  logic meta;

  // The first stage feeds the second stage only, so metastability cannot spread.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : bst_sync

// ### bst_tap.sv
// Boundary-scan test access port: controller, instruction and data registers.

module bst_tap #(
  parameter int BSR_LEN = bst_pkg::BSR_LEN_DEFAULT,
  parameter logic [31:0] IDCODE_VAL = bst_pkg::IDCODE_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic [BSR_LEN-1:0] pin_in,
  output logic [BSR_LEN-1:0] pin_out,
  output logic extest_en,
  output logic tap_in_reset
);

  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_s_n;
  logic tck_d;

  bst_pkg::bst_tap_state_t state;
  bst_pkg::bst_tap_state_t next_state;

  logic [bst_pkg::IR_W-1:0] ir;
  logic [bst_pkg::IR_W-1:0] ir_shift;
  logic bypass_bit;
  logic [bst_pkg::ID_W-1:0] id_shift;
  logic [BSR_LEN-1:0] bsr_shift;

  // Pins from the tester cross into the system clock; pulled pins idle high.
  bst_sync #(.RESET_VAL(bst_pkg::TCK_IDLE)) u_sync_tck (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(tck),
    .q(tck_s)
  );

  bst_sync #(.RESET_VAL(bst_pkg::PULLED_HIGH)) u_sync_tms (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(tms),
    .q(tms_s)
  );

  bst_sync #(.RESET_VAL(bst_pkg::PULLED_HIGH)) u_sync_tdi (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(tdi),
    .q(tdi_s)
  );

  bst_sync #(.RESET_VAL(bst_pkg::PULLED_HIGH)) u_sync_trst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(trst_n),
    .q(trst_s_n)
  );

  // Edge detection works on the synchronised clock; all pins share the same delay.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tck_d <= bst_pkg::TCK_IDLE;
    end else begin
      tck_d <= tck_s;
    end
  end

  wire tck_rise = tck_s & ~tck_d;
  wire tck_fall = ~tck_s & tck_d;
  wire trst_act = ~trst_s_n;

  // Instruction decode.
  wire sel_bsr = (ir == bst_pkg::IR_EXTEST) || (ir == bst_pkg::IR_SAMPLE);
  wire sel_id = (ir == bst_pkg::IR_IDCODE);
  wire is_extest = (ir == bst_pkg::IR_EXTEST);

  // State decode.
  wire in_shift_dr = (state == bst_pkg::ST_SHIFT_DR);
  wire in_shift_ir = (state == bst_pkg::ST_SHIFT_IR);
  wire in_cap_dr = (state == bst_pkg::ST_CAP_DR);
  wire in_cap_ir = (state == bst_pkg::ST_CAP_IR);
  wire in_upd_dr = (state == bst_pkg::ST_UPD_DR);
  wire in_upd_ir = (state == bst_pkg::ST_UPD_IR);
  wire in_reset = (state == bst_pkg::ST_RESET);

  // Action strobes: controller state and test clock edge, some also gated by the instruction; tap_clear comes from the two resets alone.
  wire tap_clear = !rst_n || trst_act;
  wire cap_ir_rise = tck_rise & in_cap_ir;
  wire shift_ir_rise = tck_rise & in_shift_ir;
  wire cap_dr_rise = tck_rise & in_cap_dr;
  wire shift_dr_rise = tck_rise & in_shift_dr;
  wire shift_id = shift_dr_rise & sel_id;
  wire shift_bsr = shift_dr_rise & sel_bsr;
  wire reset_fall = tck_fall & in_reset;
  wire upd_ir_fall = tck_fall & in_upd_ir;
  wire upd_dr_fall = tck_fall & in_upd_dr & sel_bsr;

  // Serial output selection; unknown instructions fall back to the bypass bit.
  wire dr_lsb = sel_bsr ? bsr_shift[0] : (sel_id ? id_shift[0] : bypass_bit);
  wire serial_out = in_shift_ir ? ir_shift[0] : dr_lsb;

  // Controller transitions as in the standard test-logic state diagram.
  always_comb begin
    case (state)
      bst_pkg::ST_RESET: next_state = tms_s ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
      bst_pkg::ST_IDLE: next_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_DR: next_state = tms_s ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: next_state = tms_s ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_SHIFT_DR: next_state = tms_s ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_EXIT1_DR: next_state = tms_s ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_PAUSE_DR: next_state = tms_s ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_EXIT2_DR: next_state = tms_s ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_UPD_DR: next_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_IR: next_state = tms_s ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: next_state = tms_s ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_SHIFT_IR: next_state = tms_s ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_EXIT1_IR: next_state = tms_s ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_PAUSE_IR: next_state = tms_s ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_EXIT2_IR: next_state = tms_s ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_UPD_IR: next_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      default: next_state = bst_pkg::ST_RESET;
    endcase
  end

  // Controller state; test reset wins at once, with no test clock edge needed.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || trst_act) begin
      state <= bst_pkg::ST_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // Instruction shift stage: captured and shifted on rising edges.
  always_ff @(posedge clk_sys) begin
    if (tap_clear) begin
      ir_shift <= bst_pkg::IR_CAPTURE_VAL;
    end else if (cap_ir_rise) begin
      ir_shift <= bst_pkg::IR_CAPTURE_VAL;
    end else if (shift_ir_rise) begin
      ir_shift <= {tdi_s, ir_shift[bst_pkg::IR_W-1:1]};
    end
  end

  // Data shift stages: all load in every Capture-DR; identification and boundary shift only when chosen; the bypass bit shifts in every Shift-DR.
  always_ff @(posedge clk_sys) begin
    if (tap_clear) begin
      bypass_bit <= 1'b0;
    end else if (cap_dr_rise) begin
      bypass_bit <= 1'b0;
    end else if (shift_dr_rise) begin
      bypass_bit <= tdi_s;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (tap_clear) begin
      id_shift <= '0;
    end else if (cap_dr_rise) begin
      id_shift <= IDCODE_VAL;
    end else if (shift_id) begin
      id_shift <= {tdi_s, id_shift[bst_pkg::ID_W-1:1]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (tap_clear) begin
      bsr_shift <= '0;
    end else if (cap_dr_rise) begin
      bsr_shift <= pin_in;
    end else if (shift_bsr) begin
      bsr_shift <= {tdi_s, bsr_shift[BSR_LEN-1:1]};
    end
  end

  // Instruction and boundary outputs update on the falling edge, so they never
  // change while the tester is still presenting a bit for the rising edge.
  always_ff @(posedge clk_sys) begin
    if (tap_clear) begin
      ir <= bst_pkg::IR_IDCODE;
      pin_out <= '0;
    end else if (reset_fall) begin
      ir <= bst_pkg::IR_IDCODE;
    end else if (upd_ir_fall) begin
      ir <= ir_shift;
    end else if (upd_dr_fall) begin
      pin_out <= bsr_shift;
    end
  end

  // Serial output and its enable move on falling edges, and go high at once on test reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || trst_act) begin
      tdo <= 1'b1;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo <= serial_out;
      tdo_oe_n <= ~(in_shift_dr | in_shift_ir);
    end
  end

  // Status outputs registered so they come straight from flip-flops.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      extest_en <= 1'b0;
      tap_in_reset <= 1'b1;
    end else begin
      extest_en <= is_extest & ~trst_act;
      tap_in_reset <= in_reset | trst_act;
    end
  end

endmodule : bst_tap

// ### bst_tap_monitor.sv
// Concurrent checks on the boundary-scan port pins.
module bst_tap_monitor #(
  parameter int BSR_LEN = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic [BSR_LEN-1:0] pin_out,
  input wire logic extest_en,
  input wire logic tap_in_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Five cycles covers the two synchroniser stages plus the registered flags.
  sequence trst_held;
    $fell(trst_n) ##1 !trst_n [*5];
  endsequence
  AST_TDO_FALL: assert property ($changed(tdo) && trst_n |-> !tck)
    else $error("tdo moved while tck high");
  AST_OE_FALL: assert property ($fell(tdo_oe_n) |-> !tck && !tap_in_reset)
    else $error("shift started outside a falling tck");
  AST_TMS_STEP: assert property ($fell(tap_in_reset) |-> tck && !tms)
    else $error("left reset without tck rise and tms low");
  AST_TRST: assert property (trst_held |-> tap_in_reset && tdo_oe_n)
    else $error("test reset pin ignored");
  AST_TRST_ASYNC: assert property ($fell(trst_n) ##1 (!trst_n && !tck) [*5]
    |-> !extest_en && pin_out == '0)
    else $error("test reset waited for tck");
  AST_IDLE_PULL: assert property ($rose(rst_n) |-> tap_in_reset [*4])
    else $error("controller left reset with idle pins");
  AST_UPD_FALL: assert property (($changed(pin_out) || $rose(extest_en)) && trst_n
    |-> !tck)
    else $error("update outside a falling tck");
endmodule : bst_tap_monitor

bind bst_tap bst_tap_monitor #(.BSR_LEN(BSR_LEN)) mon (.clk_sys(clk_sys), .rst_n(rst_n),
  .tck(tck), .tms(tms), .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
  .pin_out(pin_out), .extest_en(extest_en), .tap_in_reset(tap_in_reset));

// ### bst_tester.sv
// Behavioural boundary-scan tester that drives the test pins.
module bst_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b1;
  end
  // One bit per 160 ns clock; tdo is read late in the low phase, where it has settled.
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #80 o = tdo;
    tck = 1'b1;
    #80 tck = 1'b0;
    tdi = ~d;
  endtask : step
  // The clock stays low here, so the reset must act without it.
  task automatic pulse_reset;
    trst_n = 1'b0;
    #200 trst_n = 1'b1;
  endtask : pulse_reset
endmodule : bst_tester

// ### tb_top.sv
// Top-level bench: tester model, port under test and reference checks.
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe_n, extest_en, tap_in_reset;
  logic [7:0] pin_in = 8'h00;
  logic [7:0] pin_out;
  logic [31:0] d;
  logic [31:0] r;
  logic [7:0] exp_byp;
  bit byp_q[$];
  integer seed = 32'h0000_a5a4;
  int miscompares = 0;
  int cmp_count = 0;
  always #5 clk_sys = ~clk_sys;
  bst_tester tst (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));
  bst_tap #(.BSR_LEN(8)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in),
    .pin_out(pin_out), .extest_en(extest_en), .tap_in_reset(tap_in_reset));
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  // From idle: shift n bits LSB first into IR or DR, then update and return to idle.
  task automatic scan(input bit ir, input int n, input logic [31:0] din,
      output logic [31:0] dout);
    logic o;
    dout = '0;
    tst.step(1'b1, 1'b0, o);
    if (ir) begin
      tst.step(1'b1, 1'b0, o);
    end
    tst.step(1'b0, 1'b0, o);
    tst.step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      tst.step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tst.step(1'b1, 1'b0, o);
    tst.step(1'b0, 1'b0, o);
  endtask : scan
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #3;
    for (int i = 0; i < 5; i++) tst.step(1'b1, 1'b0, d[0]);
    `CHK("in_reset", 1'b1, tap_in_reset)
    tst.step(1'b0, 1'b0, d[0]);
    scan(1'b0, 32, $random(seed), d);
    `CHK("idcode", bst_pkg::IDCODE_DEFAULT, d)
    $display("test idcode done");
    r = $random(seed);
    scan(1'b1, 4, {28'h000_0000, bst_pkg::IR_BYPASS}, d);
    `CHK("ir_capture", bst_pkg::IR_CAPTURE_VAL, d[3:0])
    scan(1'b0, 8, r, d);
    byp_q = {1'b0};
    for (int i = 0; i < 8; i++) byp_q.push_back(r[i]);
    for (int i = 0; i < 8; i++) exp_byp[i] = byp_q.pop_front();
    `CHK("bypass", exp_byp, d[7:0])
    $display("test bypass done");
    @(posedge clk_sys) pin_in <= r[15:8];
    #3;
    scan(1'b1, 4, {28'h000_0000, bst_pkg::IR_EXTEST}, d);
    `CHK("extest_en", 1'b1, extest_en)
    scan(1'b0, 8, {16'h0000, r[31:16]}, d);
    `CHK("capture", pin_in, d[7:0])
    `CHK("update", r[23:16], pin_out)
    $display("test extest done");
    @(posedge clk_sys) pin_in <= r[7:0];
    #3;
    scan(1'b1, 4, {28'h000_0000, bst_pkg::IR_SAMPLE}, d);
    `CHK("sample_extest", 1'b0, extest_en)
    scan(1'b0, 8, {24'h00_0000, r[15:8]}, d);
    `CHK("sample_capture", r[7:0], d[7:0])
    `CHK("sample_update", r[15:8], pin_out)
    $display("test sample done");
    tst.pulse_reset();
    `CHK("trst_reset", 1'b1, tap_in_reset)
    `CHK("trst_extest", 1'b0, extest_en)
    tst.step(1'b0, 1'b0, d[0]);
    scan(1'b0, 32, 32'h0000_0000, d);
    `CHK("idcode_again", bst_pkg::IDCODE_DEFAULT, d)
    $display("test trst done");
    results();
  end
  initial begin
    #100000;
    miscompares++;
    $display("[FAIL] watchdog expected finish seen hang");
    results();
  end
endmodule : tb_top
